// file: src/timer_irq_enable_pkg.sv
package timer_irq_enable_pkg;
   // ======================================================
   // Register byte offsets on the AXI4-Lite port
   localparam logic [31:0] OFS_STATUS = 32'h0000_0000;
   localparam logic [31:0] OFS_TVEC = 32'h0000_0004;
   localparam logic [31:0] OFS_IE = 32'h0000_0008;
   localparam logic [31:0] OFS_IP = 32'h0000_000C;
   localparam logic [31:0] OFS_CAUSE = 32'h0000_0010;
   localparam logic [31:0] OFS_EPC = 32'h0000_0014;
   localparam logic [31:0] OFS_PRIV = 32'h0000_0018;

   // ======================================================
   // Field positions
   localparam int STAT_IE_BIT = 3;
   localparam int STAT_PIE_BIT = 7;
   localparam int STAT_PP_LO = 11;
   localparam int STAT_PP_HI = 12;
   localparam int IE_SOFT_BIT = 3;
   localparam int IE_TIMER_BIT = 7;
   localparam int IE_EXT_BIT = 11;
   localparam int CAUSE_IRQ_BIT = 31;
   localparam int CAUSE_CODE_W = 10;

   // ======================================================
   // Encodings
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_VECTORED = 2'h1;
   localparam logic [1:0] PRIV_MACHINE = 2'h3;
   localparam logic [9:0] CODE_SOFT = 10'h003;
   localparam logic [9:0] CODE_TIMER = 10'h007;
   localparam logic [9:0] CODE_EXT = 10'h00B;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================
   // Values after reset
   localparam logic [29:0] TVEC_BASE_RST = 30'h0000_0000;
   localparam logic [1:0] TVEC_MODE_RST = 2'h0;
   localparam logic [1:0] PRIV_RST = 2'h3;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// file: src/timer_irq_enable_irq_arb.sv
module timer_irq_enable_irq_arb (
   input wire logic pend_soft,
   input wire logic pend_timer,
   input wire logic pend_ext,
   output logic any,
   output logic [9:0] code
);
   // Fixed order: external, then software, then timer
   always_comb begin
      any = pend_soft | pend_timer | pend_ext;
      if (pend_ext) begin
         code = timer_irq_enable_pkg::CODE_EXT;
      end else if (pend_soft) begin
         code = timer_irq_enable_pkg::CODE_SOFT;
      end else begin
         code = timer_irq_enable_pkg::CODE_TIMER;
      end
   end
endmodule

// file: src/timer_irq_enable_axil_slave.sv
module timer_irq_enable_axil_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic [31:0] addr_reg, addr_next, data_reg, data_next;
   logic [3:0] strb_reg, strb_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;

   assign awready = !aw_have_reg;
   assign wready = !w_have_reg;
   assign arready = !rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;
   assign wr_addr = addr_reg;
   assign wr_data = data_reg;
   assign wr_strb = strb_reg;
   // Commit only once the previous response has gone, one write in flight
   assign wr_en = aw_have_reg && w_have_reg && !bvalid_reg;

   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      strb_next = strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      if (awvalid && !aw_have_reg) begin
         aw_have_next = 1'b1;
         addr_next = awaddr;
      end
      if (wvalid && !w_have_reg) begin
         w_have_next = 1'b1;
         data_next = wdata;
         strb_next = wstrb;
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_en) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = wr_err ? timer_irq_enable_pkg::RESP_SLVERR : timer_irq_enable_pkg::RESP_OKAY;
      end
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      if (arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rdata_next = rd_data;
         rresp_next = rd_err ? timer_irq_enable_pkg::RESP_SLVERR : timer_irq_enable_pkg::RESP_OKAY;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         addr_reg <= timer_irq_enable_pkg::WORD_RST;
         data_reg <= timer_irq_enable_pkg::WORD_RST;
         strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= timer_irq_enable_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= timer_irq_enable_pkg::RESP_OKAY;
         rdata_reg <= timer_irq_enable_pkg::WORD_RST;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         strb_reg <= strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end
endmodule

// file: src/timer_irq_enable_top.sv
module timer_irq_enable_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic IRQ_SOFT,
   input wire logic IRQ_TIMER,
   input wire logic IRQ_EXT,
   input wire logic EXC_REQ,
   input wire logic [9:0] EXC_CODE,
   input wire logic MACHINE_RETURN_INSTR,
   input wire logic [31:0] PC_CUR,
   output logic TRAP_TAKEN,
   output logic REDIRECT_VALID,
   output logic [31:0] REDIRECT_PC,
   output logic [1:0] PRIV_MODE
);
   // ======================================================
   // State
   logic global_ie_reg, global_ie_next;
   logic previous_irq_enable_reg, previous_irq_enable_next;
   logic [1:0] previous_privilege_reg, previous_privilege_next;
   logic [1:0] priv_reg, priv_next;
   logic [29:0] tvec_base_reg, tvec_base_next;
   logic [1:0] tvec_mode_reg, tvec_mode_next;
   logic soft_irq_enable_reg, soft_irq_enable_next;
   logic timer_irq_enable_reg, timer_irq_enable_next;
   logic external_irq_enable_reg, external_irq_enable_next;
   logic cause_irq_reg, cause_irq_next;
   logic [9:0] cause_code_reg, cause_code_next;
   logic [31:0] epc_reg, epc_next;
   logic trap_reg, trap_next;
   logic redir_reg, redir_next;
   logic [31:0] redir_pc_reg, redir_pc_next;

   logic wr_en, wr_err, rd_err, irq_any, irq_take;
   logic [31:0] wr_addr, wr_data, rd_data, st_word, tv_word, ie_word, ip_word, cs_word, wm;
   logic [3:0] wr_strb;
   logic [9:0] irq_code;

   // ======================================================
   // Register bus
   timer_irq_enable_axil_slave u_bus (
      .clk(CLK),
      .rst_n(RST_N),
      .awaddr(AWADDR),
      .awvalid(AWVALID),
      .awready(AWREADY),
      .wdata(WDATA),
      .wstrb(WSTRB),
      .wvalid(WVALID),
      .wready(WREADY),
      .bresp(BRESP),
      .bvalid(BVALID),
      .bready(BREADY),
      .araddr(ARADDR),
      .arvalid(ARVALID),
      .arready(ARREADY),
      .rdata(RDATA),
      .rresp(RRESP),
      .rvalid(RVALID),
      .rready(RREADY),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // ======================================================
   // Register images; reserved bits read as zero
   assign st_word = {19'h0, previous_privilege_reg, 3'h0, previous_irq_enable_reg, 3'h0,
                     global_ie_reg, 3'h0};
   assign tv_word = {tvec_base_reg, tvec_mode_reg};
   assign ie_word = {20'h0, external_irq_enable_reg, 3'h0, timer_irq_enable_reg, 3'h0,
                     soft_irq_enable_reg, 3'h0};
   assign ip_word = {20'h0, IRQ_EXT, 3'h0, IRQ_TIMER, 3'h0, IRQ_SOFT, 3'h0};
   assign cs_word = {cause_irq_reg, 21'h0, cause_code_reg};
   assign wm = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // Read image follows ARADDR, so the slave captures it at the take edge
   always_comb begin
      rd_err = 1'b0;
      if (ARADDR == timer_irq_enable_pkg::OFS_STATUS) begin
         rd_data = st_word;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_TVEC) begin
         rd_data = tv_word;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_IE) begin
         rd_data = ie_word;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_IP) begin
         rd_data = ip_word;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_CAUSE) begin
         rd_data = cs_word;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_EPC) begin
         rd_data = epc_reg;
      end else if (ARADDR == timer_irq_enable_pkg::OFS_PRIV) begin
         rd_data = {30'h0, priv_reg};
      end else begin
         rd_data = timer_irq_enable_pkg::WORD_RST;
         rd_err = 1'b1;
      end
   end

   // ======================================================
   // Interrupt selection
   // Only enabled sources compete, so a masked line never blocks a lower one
   timer_irq_enable_irq_arb u_arb (
      .pend_soft(IRQ_SOFT & soft_irq_enable_reg),
      .pend_timer(IRQ_TIMER & timer_irq_enable_reg),
      .pend_ext(IRQ_EXT & external_irq_enable_reg),
      .any(irq_any),
      .code(irq_code)
   );

   // Synchronous exceptions win over interrupts in the same cycle
   assign irq_take = global_ie_reg && irq_any && !EXC_REQ;

   // ======================================================
   // Trap entry, return and software writes
   always_comb begin
      logic [31:0] merged;
      merged = word_merge(wr_data);
      global_ie_next = global_ie_reg;
      previous_irq_enable_next = previous_irq_enable_reg;
      previous_privilege_next = previous_privilege_reg;
      priv_next = priv_reg;
      tvec_base_next = tvec_base_reg;
      tvec_mode_next = tvec_mode_reg;
      soft_irq_enable_next = soft_irq_enable_reg;
      timer_irq_enable_next = timer_irq_enable_reg;
      external_irq_enable_next = external_irq_enable_reg;
      cause_irq_next = cause_irq_reg;
      cause_code_next = cause_code_reg;
      epc_next = epc_reg;
      trap_next = 1'b0;
      redir_next = 1'b0;
      redir_pc_next = redir_pc_reg;
      wr_err = 1'b0;

      if (wr_en) begin
         if (wr_addr == timer_irq_enable_pkg::OFS_STATUS) begin
            // Reserved status bits are not stored, so writes leave them as they read
            global_ie_next = merged[timer_irq_enable_pkg::STAT_IE_BIT];
            previous_irq_enable_next = merged[timer_irq_enable_pkg::STAT_PIE_BIT];
            previous_privilege_next = merged[timer_irq_enable_pkg::STAT_PP_HI:timer_irq_enable_pkg::STAT_PP_LO];
         end else if (wr_addr == timer_irq_enable_pkg::OFS_TVEC) begin
            tvec_base_next = merged[31:2];
            // Reserved modes are refused and the old mode is kept
            if (merged[1:0] == timer_irq_enable_pkg::MODE_DIRECT ||
                merged[1:0] == timer_irq_enable_pkg::MODE_VECTORED) begin
               tvec_mode_next = merged[1:0];
            end
         end else if (wr_addr == timer_irq_enable_pkg::OFS_IE) begin
            soft_irq_enable_next = merged[timer_irq_enable_pkg::IE_SOFT_BIT];
            timer_irq_enable_next = merged[timer_irq_enable_pkg::IE_TIMER_BIT];
            external_irq_enable_next = merged[timer_irq_enable_pkg::IE_EXT_BIT];
         end else if (wr_addr == timer_irq_enable_pkg::OFS_CAUSE) begin
            cause_irq_next = merged[timer_irq_enable_pkg::CAUSE_IRQ_BIT];
            cause_code_next = merged[timer_irq_enable_pkg::CAUSE_CODE_W-1:0];
         end else if (wr_addr == timer_irq_enable_pkg::OFS_EPC) begin
            epc_next = {merged[31:2], 2'b00};
         end else if (wr_addr == timer_irq_enable_pkg::OFS_IP || wr_addr == timer_irq_enable_pkg::OFS_PRIV) begin
            // Read-only words: write accepted and ignored
            wr_err = 1'b0;
         end else begin
            wr_err = 1'b1;
         end
      end

      // A return that meets a trap in the same cycle is dropped; the trap wins
      if (MACHINE_RETURN_INSTR && !EXC_REQ && !irq_take) begin
         priv_next = previous_privilege_reg;
         global_ie_next = previous_irq_enable_reg;
         previous_irq_enable_next = 1'b1;
         redir_next = 1'b1;
         redir_pc_next = epc_reg;
      end

      // Hardware entry overrides a software write to the same fields
      if (EXC_REQ || irq_take) begin
         previous_irq_enable_next = global_ie_reg;
         global_ie_next = 1'b0;
         previous_privilege_next = priv_reg;
         priv_next = timer_irq_enable_pkg::PRIV_MACHINE;
         epc_next = PC_CUR;
         cause_irq_next = irq_take;
         cause_code_next = irq_take ? irq_code : EXC_CODE;
         trap_next = 1'b1;
         redir_next = 1'b1;
         if (irq_take && tvec_mode_reg == timer_irq_enable_pkg::MODE_VECTORED) begin
            // Base is assumed 64-byte aligned by software, so a plain add is enough
            redir_pc_next = 32'({tvec_base_reg, 2'b00} +
                                {20'h0, irq_code, 2'b00});
         end else begin
            redir_pc_next = {tvec_base_reg, 2'b00};
         end
      end
   end

   // Strobe merge over the current image; words with no image merge over zero
   function automatic logic [31:0] word_merge(input logic [31:0] d);
      logic [31:0] old;
      old = timer_irq_enable_pkg::WORD_RST;
      if (wr_addr == timer_irq_enable_pkg::OFS_STATUS) begin
         old = st_word;
      end else if (wr_addr == timer_irq_enable_pkg::OFS_TVEC) begin
         old = tv_word;
      end else if (wr_addr == timer_irq_enable_pkg::OFS_IE) begin
         old = ie_word;
      end else if (wr_addr == timer_irq_enable_pkg::OFS_CAUSE) begin
         old = cs_word;
      end else if (wr_addr == timer_irq_enable_pkg::OFS_EPC) begin
         old = epc_reg;
      end
      return (old & ~wm) | (d & wm);
   endfunction

   // ======================================================
   // Registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         global_ie_reg <= 1'b0;
         previous_irq_enable_reg <= 1'b0;
         previous_privilege_reg <= timer_irq_enable_pkg::PRIV_RST;
         priv_reg <= timer_irq_enable_pkg::PRIV_RST;
         tvec_base_reg <= timer_irq_enable_pkg::TVEC_BASE_RST;
         tvec_mode_reg <= timer_irq_enable_pkg::TVEC_MODE_RST;
         soft_irq_enable_reg <= 1'b0;
         timer_irq_enable_reg <= 1'b0;
         external_irq_enable_reg <= 1'b0;
         cause_irq_reg <= 1'b0;
         cause_code_reg <= 10'h000;
         epc_reg <= timer_irq_enable_pkg::WORD_RST;
         trap_reg <= 1'b0;
         redir_reg <= 1'b0;
         redir_pc_reg <= timer_irq_enable_pkg::WORD_RST;
      end else begin
         global_ie_reg <= global_ie_next;
         previous_irq_enable_reg <= previous_irq_enable_next;
         previous_privilege_reg <= previous_privilege_next;
         priv_reg <= priv_next;
         tvec_base_reg <= tvec_base_next;
         tvec_mode_reg <= tvec_mode_next;
         soft_irq_enable_reg <= soft_irq_enable_next;
         timer_irq_enable_reg <= timer_irq_enable_next;
         external_irq_enable_reg <= external_irq_enable_next;
         cause_irq_reg <= cause_irq_next;
         cause_code_reg <= cause_code_next;
         epc_reg <= epc_next;
         trap_reg <= trap_next;
         redir_reg <= redir_next;
         redir_pc_reg <= redir_pc_next;
      end
   end

   // ======================================================
   // Outputs come straight from flip-flops
   assign TRAP_TAKEN = trap_reg;
   assign REDIRECT_VALID = redir_reg;
   assign REDIRECT_PC = redir_pc_reg;
   assign PRIV_MODE = priv_reg;
endmodule

// file: dv/timer_irq_enable_props.sv
module timer_irq_enable_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic IRQ_SOFT,
   input wire logic IRQ_TIMER,
   input wire logic IRQ_EXT,
   input wire logic EXC_REQ,
   input wire logic MACHINE_RETURN_INSTR,
   input wire logic TRAP_TAKEN,
   input wire logic REDIRECT_VALID,
   input wire logic [31:0] REDIRECT_PC,
   input wire logic [1:0] PRIV_MODE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ==========================================
   // Trap entry and return
   gate_after_trap_a: assert property (TRAP_TAKEN && !EXC_REQ |=> !TRAP_TAKEN)
      else $error("second trap right after an interrupt entry");
   trap_cause_a: assert property (TRAP_TAKEN |-> $past(EXC_REQ) || $past(IRQ_SOFT)
      || $past(IRQ_TIMER) || $past(IRQ_EXT)) else $error("trap without a source");
   trap_redirect_a: assert property (TRAP_TAKEN |-> REDIRECT_VALID)
      else $error("trap without redirect");
   trap_priv_a: assert property (TRAP_TAKEN |-> PRIV_MODE == timer_irq_enable_pkg::PRIV_MACHINE)
      else $error("trap did not enter machine mode");
   exc_entry_a: assert property (EXC_REQ |=> TRAP_TAKEN)
      else $error("exception not taken");
   ret_exit_a: assert property (MACHINE_RETURN_INSTR |=> REDIRECT_VALID)
      else $error("return without redirect");
   redirect_hold_a: assert property (!REDIRECT_VALID |-> $stable(REDIRECT_PC)
      && $stable(PRIV_MODE))
      else $error("pc or privilege moved without redirect");
   // ==========================================
   // Register bus handshakes
   write_resp_a: assert property (AWVALID && AWREADY && WVALID && WREADY && !BVALID
      |-> ##2 BVALID) else $error("write response late");
   read_resp_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read response late");
   b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   ar_block_a: assert property (RVALID |-> !ARREADY)
      else $error("read accepted while answer pending");
   cover property (TRAP_TAKEN && !$past(EXC_REQ));
   cover property (MACHINE_RETURN_INSTR ##1 REDIRECT_VALID);
   cover property (EXC_REQ ##1 TRAP_TAKEN);
endmodule

bind timer_irq_enable_top timer_irq_enable_props u_props (.CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
   .IRQ_SOFT(IRQ_SOFT), .IRQ_TIMER(IRQ_TIMER), .IRQ_EXT(IRQ_EXT), .EXC_REQ(EXC_REQ),
   .MACHINE_RETURN_INSTR(MACHINE_RETURN_INSTR), .TRAP_TAKEN(TRAP_TAKEN),
   .REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_PC(REDIRECT_PC), .PRIV_MODE(PRIV_MODE));

// file: dv/timer_irq_enable_irq_src.sv
module timer_irq_enable_irq_src (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] req,
   input wire logic slow,
   output logic irq_soft,
   output logic irq_timer,
   output logic irq_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Sources hold their level until cleared, like a timer compare
   // Slow mode adds a stage, as a controller gateway would
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic [2:0] out_reg;
   logic [2:0] out_next;
   always_comb begin
      stage_next = req;
      out_next = slow ? stage_reg : req;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_reg <= 3'h0;
         out_reg <= 3'h0;
      end else begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end
   assign irq_soft = out_reg[0];
   assign irq_timer = out_reg[1];
   assign irq_ext = out_reg[2];
endmodule

// file: dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_ST = timer_irq_enable_pkg::OFS_STATUS;
   localparam logic [31:0] A_IE = timer_irq_enable_pkg::OFS_IE;
   localparam logic [31:0] BASE = 32'h0000_1040;
   logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, irq_soft, irq_timer, irq_ext, exc_req, ret_instr, trap, rv, slow;
   logic [31:0] awaddr, wdata, araddr, rdata, rpc, pc_cur, d;
   logic [1:0] bresp, rresp, priv, r;
   logic [9:0] exc_code;
   logic [2:0] req;
   int fail_count, n_checks, redir_cnt, n0, i;
   logic [31:0] last_pc;
   logic last_trap;
   timer_irq_enable_top uut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .IRQ_SOFT(irq_soft), .IRQ_TIMER(irq_timer), .IRQ_EXT(irq_ext), .EXC_REQ(exc_req),
      .EXC_CODE(exc_code), .MACHINE_RETURN_INSTR(ret_instr), .PC_CUR(pc_cur), .TRAP_TAKEN(trap),
      .REDIRECT_VALID(rv), .REDIRECT_PC(rpc), .PRIV_MODE(priv));
   timer_irq_enable_irq_src src (.clk(clk), .rst_n(rst_n), .req(req), .slow(slow),
      .irq_soft(irq_soft), .irq_timer(irq_timer), .irq_ext(irq_ext));
   // ==========================================
   // Checking and closing
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // Bus master: valids held until the edge that takes them
   task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 40 && !tb; k++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) begin
         fail_count++;
         give_verdict();
      end
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ta, tv;
      tv = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 40 && !tv; k++) begin
         @(negedge clk);
         ta = arvalid && arready;
         tv = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tv) rready <= 1'b0;
      end
      if (!tv) begin
         fail_count++;
         give_verdict();
      end
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0] rs;
      rd(a, v, rs);
      check(v, exp);
   endtask
   // ==========================================
   // Core side
   task automatic pulse(input logic e, input logic m);
      @(posedge clk);
      exc_req <= e;
      ret_instr <= m;
      @(posedge clk);
      exc_req <= 1'b0;
      ret_instr <= 1'b0;
   endtask
   task automatic expect_redir(input logic [31:0] pc, input logic t);
      for (int k = 0; k < 20 && redir_cnt == n0; k++) @(negedge clk);
      check(32'(redir_cnt - n0), 32'h1);
      check(last_pc, pc);
      check({31'h0, last_trap}, {31'h0, t});
      if (redir_cnt == n0) give_verdict();
   endtask
   task automatic expect_none();
      repeat (8) @(negedge clk);
      check(32'(redir_cnt - n0), 32'h0);
   endtask
   always @(negedge clk) begin
      if (rv === 1'b1) begin
         redir_cnt <= redir_cnt + 1;
         last_pc <= rpc;
         last_trap <= trap;
      end
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, exc_req, ret_instr, slow} = '0;
      {awaddr, wdata, araddr, exc_code, req} = '0;
      pc_cur = 32'h0000_2468;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(A_ST, 32'h0000_1800);
      rd_chk(timer_irq_enable_pkg::OFS_PRIV, 32'h3);
      rd(32'h0000_0020, d, r);
      check({d[29:0], r}, {30'h0, timer_irq_enable_pkg::RESP_SLVERR});
      wr(32'h0000_0020, 32'hFFFF_FFFF, r);
      check({30'h0, r}, {30'h0, timer_irq_enable_pkg::RESP_SLVERR});
      wr(A_ST, 32'hFFFF_FFFF, r);
      rd_chk(A_ST, 32'h0000_1888);
      wr(A_IE, 32'hFFFF_FFFF, r);
      rd_chk(A_IE, 32'h0000_0888);
      // Vectored base is 64-byte aligned; mode 3 must leave the mode alone
      wr(timer_irq_enable_pkg::OFS_TVEC, BASE | 32'h1, r);
      wr(timer_irq_enable_pkg::OFS_TVEC, BASE | 32'h3, r);
      rd_chk(timer_irq_enable_pkg::OFS_TVEC, BASE | 32'h1);
      $display("test registers done");
      n0 = redir_cnt;
      wr(A_ST, 32'h0000_1800, r);
      slow <= 1'b1;
      req <= 3'h7;
      expect_none();
      rd_chk(timer_irq_enable_pkg::OFS_IP, 32'h0000_0888);
      wr(A_IE, 32'h0, r);
      wr(A_ST, 32'h0000_1808, r);
      expect_none();
      wr(A_ST, 32'h0000_1800, r);
      wr(A_IE, 32'h0000_0888, r);
      $display("test gating done");
      // Expected service order: external, software, timer
      for (i = 0; i < 3; i++) begin
         d = (i == 0) ? 32'd11 : (i == 1) ? 32'd3 : 32'd7;
         n0 = redir_cnt;
         wr(A_ST, 32'h0000_1808, r);
         expect_redir(BASE + 4 * d, 1'b1);
         rd_chk(timer_irq_enable_pkg::OFS_CAUSE, 32'h8000_0000 | d);
         rd_chk(A_ST, 32'h0000_1880);
         rd_chk(timer_irq_enable_pkg::OFS_EPC, 32'h0000_2468);
         req <= req & ~((i == 0) ? 3'h4 : (i == 1) ? 3'h1 : 3'h2);
      end
      $display("test vectored done");
      n0 = redir_cnt;
      pulse(1'b0, 1'b1);
      expect_redir(32'h0000_2468, 1'b0);
      rd_chk(A_ST, 32'h0000_1888);
      wr(A_ST, 32'h0, r);
      n0 = redir_cnt;
      pulse(1'b0, 1'b1);
      expect_redir(32'h0000_2468, 1'b0);
      check({30'h0, priv}, 32'h0);
      @(posedge clk);
      exc_code <= 10'h005;
      pc_cur <= 32'h0000_3330;
      n0 = redir_cnt;
      pulse(1'b1, 1'b0);
      expect_redir(BASE, 1'b1);
      check({30'h0, priv}, {30'h0, timer_irq_enable_pkg::PRIV_MACHINE});
      rd_chk(timer_irq_enable_pkg::OFS_CAUSE, 32'h0000_0005);
      rd_chk(A_ST, 32'h0000_0000);
      rd_chk(timer_irq_enable_pkg::OFS_EPC, 32'h0000_3330);
      $display("test return and exception done");
      wr(timer_irq_enable_pkg::OFS_TVEC, BASE, r);
      slow <= 1'b0;
      req <= 3'h1;
      n0 = redir_cnt;
      wr(A_ST, 32'h0000_0008, r);
      expect_redir(BASE, 1'b1);
      rd_chk(timer_irq_enable_pkg::OFS_CAUSE, 32'h8000_0003);
      req <= 3'h0;
      $display("test direct done");
      give_verdict();
   end
endmodule
